// ### rtl/wrs_pkg.sv
/*
  Shared constants for the watchdog and reset supervisor: register map,
  field positions, reset values, default timing counts and state codes.
  Assumes a single 50 MHz clock domain and a 32-bit classic Wishbone bus.
*/
package wrs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_CAUSE  = 8'h0C;

  // Control fields
  localparam int CTRL_WINDOWED_BIT = 0;
  localparam int CTRL_FORCE_BIT    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status fields
  localparam int ST_RESET_LOW_BIT  = 0;
  localparam int ST_FAST_FAULT_BIT = 1;
  localparam int ST_SLOW_FAULT_BIT = 2;
  localparam int ST_WD_ENABLED_BIT = 3;
  localparam int ST_EXTENDED_BIT   = 4;

  // Cause fields
  localparam int CAUSE_UV_SUPPLY_BIT  = 0;
  localparam int CAUSE_UV_MONITOR_BIT = 1;
  localparam int CAUSE_MANUAL_BIT     = 2;

  // Default timing counts, in 20 ns clock cycles
  localparam int RESET_TIMEOUT_DEFAULT = 10000;
  localparam int BASIC_WD_DEFAULT      = 50000;
  localparam int SLOW_WINDOW_DEFAULT   = 400000;

  // Timing field widths and ratios
  localparam int CNT_W         = 32;
  localparam int EXTEND_SHIFT  = 7;
  localparam int RATIO8_SHIFT  = 3;
  localparam int RATIO16_SHIFT = 4;
  localparam int RATIO64_SHIFT = 6;

  // Synchronised pin bundle positions
  localparam int PIN_UV_SUPPLY  = 0;
  localparam int PIN_UV_MONITOR = 1;
  localparam int PIN_MANUAL_B   = 2;
  localparam int PIN_MODE_SEL   = 3;
  localparam int PIN_STRAP_A    = 4;
  localparam int PIN_STRAP_B    = 5;
  localparam int PIN_KICK       = 6;
  localparam int PIN_SWT_GND    = 7;
  localparam int PIN_W          = 8;
  localparam logic [7:0] PIN_IDLE = 8'h44;

  typedef enum logic [1:0] {
    WRS_HOLD    = 2'b00,
    WRS_TIMEOUT = 2'b01,
    WRS_RUN     = 2'b10
  } wrs_state_e;

endpackage

// ### rtl/wrs_supervisor.sv
/*
  Watchdog and reset supervisor: drives an active-low processor reset from
  undervoltage, manual reset and watchdog faults, with a single-timeout or
  a windowed watchdog selected by software over classic Wishbone.
  Assumes all pins are asynchronous and synchronised here; one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode select low uses basic timeout; high multiplies it by 128.
// - In the single variant, any level change on mode select clears the watchdog timer.
// - Single variant clears timer on any kick transition or while reset.
// - Single variant disabled entirely when timing capacitor strap is grounded.
// - Windowed variant faults on kicks closer than fast or beyond slow limit.
// - Windowed timer idles during reset and counts only after release.
// - Windowed timer restarts on valid in-window falling kick; cleared in reset.
// - Windowed watchdog disabled when strap a high and strap b low.
// - Fast limit is slow limit divided by 8, 16 or 64 per straps.
// - Reset held low during undervoltage or while manual reset is low.
// - After all causes clear, reset stays low one timeout then releases.
// - Any watchdog fault gives a reset pulse of exactly the timeout.
// - Windowed variant ignores kick edges while reset is asserted.
// - In the windowed variant, any level change on either ratio strap clears the watchdog timer.
module wrs_supervisor #(
  parameter int RESET_TIMEOUT_CYCLES = wrs_pkg::RESET_TIMEOUT_DEFAULT,
  parameter int BASIC_WD_CYCLES      = wrs_pkg::BASIC_WD_DEFAULT,
  parameter int SLOW_WINDOW_CYCLES   = wrs_pkg::SLOW_WINDOW_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Supply monitor and manual reset
  input  wire logic        undervoltage_supply,
  input  wire logic        undervoltage_monitor,
  input  wire logic        manual_reset_input_b,
  // Watchdog pins and straps
  input  wire logic        watchdog_mode_select,
  input  wire logic        window_ratio_strap_a,
  input  wire logic        window_ratio_strap_b,
  input  wire logic        watchdog_kick_input,
  input  wire logic        watchdog_timing_capacitor_gnd,
  // Processor reset
  output logic             reset_out_b
);

  localparam int CW = wrs_pkg::CNT_W;
  localparam logic [CW-1:0] RESET_LAST = CW'(RESET_TIMEOUT_CYCLES - 1);
  localparam logic [CW-1:0] BASIC_CNT  = CW'(BASIC_WD_CYCLES);
  localparam logic [CW-1:0] SLOW_LAST  = CW'(SLOW_WINDOW_CYCLES - 1);
  localparam logic [CW-1:0] SLOW_CNT   = CW'(SLOW_WINDOW_CYCLES);

  logic [wrs_pkg::PIN_W-1:0] pins_async;
  logic [wrs_pkg::PIN_W-1:0] pins;
  logic [wrs_pkg::PIN_W-1:0] pins_q;

  wrs_pkg::wrs_state_e state;
  wrs_pkg::wrs_state_e next_state;

  logic [CW-1:0] rst_count;
  logic [CW-1:0] wd_count;
  logic [CW-1:0] next_wd_count;
  logic [CW-1:0] wd_last;
  logic [CW-1:0] fast_cnt;

  logic          ctrl_windowed;
  logic          ctrl_force;
  logic          stat_fast;
  logic          stat_slow;

  logic          cause_any;
  logic          kick_fall;
  logic          kick_toggle;
  logic          cfg_change;
  logic          wd_enabled;
  logic          wd_counting;
  logic          fault_single;
  logic          fault_fast;
  logic          fault_slow;
  logic          fault_any;
  logic          wb_req;
  logic          wb_wr;
  logic          wb_wr_ctrl;
  logic          wb_wr_status;

  // Pin capture
  assign pins_async = {watchdog_timing_capacitor_gnd, watchdog_kick_input,
                       window_ratio_strap_b, window_ratio_strap_a,
                       watchdog_mode_select, manual_reset_input_b,
                       undervoltage_monitor, undervoltage_supply};

  wrs_sync #(
    .W    (wrs_pkg::PIN_W),
    .INIT (wrs_pkg::PIN_IDLE)
  ) u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_async (pins_async),
    .pin_sync  (pins)
  );

  // Pin edges arrive two cycles late through the synchroniser; the
  // timeouts are long enough that this skew is harmless
  // Previous synchronised levels, used for edge and change detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= wrs_pkg::PIN_IDLE;
    end else begin
      pins_q <= pins;
    end
  end

  // Reset causes; a software force acts like a held manual reset
  assign cause_any = pins[wrs_pkg::PIN_UV_SUPPLY] | pins[wrs_pkg::PIN_UV_MONITOR]
                   | ~pins[wrs_pkg::PIN_MANUAL_B] | ctrl_force;

  // First kick after release is timed from zero, so a prompt kick
  // right after reset can already count as too early
  // Kick edges on the synchronised level only
  assign kick_fall   = pins_q[wrs_pkg::PIN_KICK] & ~pins[wrs_pkg::PIN_KICK];
  assign kick_toggle = pins_q[wrs_pkg::PIN_KICK] ^ pins[wrs_pkg::PIN_KICK];

  // Any configuration change of the active variant restarts the timing
  always_comb begin
    if (ctrl_windowed) begin
      cfg_change = (pins_q[wrs_pkg::PIN_STRAP_A] ^ pins[wrs_pkg::PIN_STRAP_A])
                 | (pins_q[wrs_pkg::PIN_STRAP_B] ^ pins[wrs_pkg::PIN_STRAP_B]);
    end else begin
      cfg_change = pins_q[wrs_pkg::PIN_MODE_SEL] ^ pins[wrs_pkg::PIN_MODE_SEL];
    end
  end

  // Watchdog enable per variant
  always_comb begin
    if (ctrl_windowed) begin
      wd_enabled = ~(pins[wrs_pkg::PIN_STRAP_A] & ~pins[wrs_pkg::PIN_STRAP_B]);
    end else begin
      wd_enabled = ~pins[wrs_pkg::PIN_SWT_GND];
    end
  end

  // Single-variant terminal count, normal or extended
  assign wd_last = pins[wrs_pkg::PIN_MODE_SEL]
                 ? (BASIC_CNT << wrs_pkg::EXTEND_SHIFT) - CW'(1)
                 : BASIC_CNT - CW'(1);

  // Fast window limit from the strap ratio
  always_comb begin
    unique case ({pins[wrs_pkg::PIN_STRAP_A], pins[wrs_pkg::PIN_STRAP_B]})
      2'b00: fast_cnt = SLOW_CNT >> wrs_pkg::RATIO8_SHIFT;
      2'b01: fast_cnt = SLOW_CNT >> wrs_pkg::RATIO16_SHIFT;
      2'b11: fast_cnt = SLOW_CNT >> wrs_pkg::RATIO64_SHIFT;
      // Disabled code; no fault is ever raised through it
      2'b10: fast_cnt = '0;
    endcase
  end

  // Timer only runs with reset released, so kicks in reset are ignored
  assign wd_counting = (state == wrs_pkg::WRS_RUN) & wd_enabled;

  // Missed kick: the processor owes an edge before the count expires
  assign fault_single = wd_counting & ~ctrl_windowed & ~cfg_change
                      & ~kick_toggle & (wd_count == wd_last);
  assign fault_fast   = wd_counting & ctrl_windowed & ~cfg_change
                      & kick_fall & (wd_count < fast_cnt);
  assign fault_slow   = wd_counting & ctrl_windowed & ~cfg_change
                      & ~kick_fall & (wd_count == SLOW_LAST);
  assign fault_any    = fault_single | fault_fast | fault_slow;

  // Watchdog timer next value
  always_comb begin
    next_wd_count = wd_count + CW'(1);
    if (!wd_counting) begin
      next_wd_count = '0;
    end else if (cfg_change) begin
      next_wd_count = '0;
    end else if (fault_any) begin
      next_wd_count = '0;
    end else if (!ctrl_windowed && kick_toggle) begin
      next_wd_count = '0;
    end else if (ctrl_windowed && kick_fall) begin
      next_wd_count = '0;
    end
  end

  // Watchdog timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_count <= '0;
    end else begin
      wd_count <= next_wd_count;
    end
  end

  // Reset output sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      wrs_pkg::WRS_HOLD: begin
        if (!cause_any) begin
          next_state = wrs_pkg::WRS_TIMEOUT;
        end
      end
      wrs_pkg::WRS_TIMEOUT: begin
        if (cause_any) begin
          next_state = wrs_pkg::WRS_HOLD;
        end else if (rst_count == RESET_LAST) begin
          next_state = wrs_pkg::WRS_RUN;
        end
      end
      wrs_pkg::WRS_RUN: begin
        if (cause_any) begin
          next_state = wrs_pkg::WRS_HOLD;
        end else if (fault_any) begin
          next_state = wrs_pkg::WRS_TIMEOUT;
        end
      end
      default: begin
        next_state = wrs_pkg::WRS_HOLD;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= wrs_pkg::WRS_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Timeout counter restarts on every entry into the timeout state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_count <= '0;
    end else if (state != wrs_pkg::WRS_TIMEOUT) begin
      rst_count <= '0;
    end else begin
      rst_count <= rst_count + CW'(1);
    end
  end

  // Registered so the pin never glitches on decode
  // Taken from next_state so the pin rises on the edge the run state starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_b <= 1'b0;
    end else begin
      reset_out_b <= (next_state == wrs_pkg::WRS_RUN);
    end
  end

  // Wishbone: one wait state, ack drops the cycle after it is given
  assign wb_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge where the master sees ack, not when taken,
  // so a master that gives up before ack leaves no trace
  assign wb_wr        = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wb_wr_ctrl   = wb_wr & (wb_adr_i == wrs_pkg::OFS_CTRL);
  assign wb_wr_status = wb_wr & (wb_adr_i == wrs_pkg::OFS_STATUS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Control register; a variant change is not a configuration change and keeps the timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_windowed <= wrs_pkg::CTRL_RESET[wrs_pkg::CTRL_WINDOWED_BIT];
      ctrl_force    <= wrs_pkg::CTRL_RESET[wrs_pkg::CTRL_FORCE_BIT];
    end else if (wb_wr_ctrl) begin
      ctrl_windowed <= wb_dat_i[wrs_pkg::CTRL_WINDOWED_BIT];
      ctrl_force    <= wb_dat_i[wrs_pkg::CTRL_FORCE_BIT];
    end
  end

  // Sticky fast fault, write one to clear; a new fault wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_fast <= 1'b0;
    end else if (fault_fast) begin
      stat_fast <= 1'b1;
    end else if (wb_wr_status && wb_dat_i[wrs_pkg::ST_FAST_FAULT_BIT]) begin
      stat_fast <= 1'b0;
    end
  end

  // Sticky slow fault; a single-variant missed kick lands here as well
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_slow <= 1'b0;
    end else if (fault_slow | fault_single) begin
      stat_slow <= 1'b1;
    end else if (wb_wr_status && wb_dat_i[wrs_pkg::ST_SLOW_FAULT_BIT]) begin
      stat_slow <= 1'b0;
    end
  end

  // Read data, zero for unmapped offsets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (wb_req) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        wrs_pkg::OFS_CTRL: begin
          wb_dat_o[wrs_pkg::CTRL_WINDOWED_BIT] <= ctrl_windowed;
          wb_dat_o[wrs_pkg::CTRL_FORCE_BIT]    <= ctrl_force;
        end
        wrs_pkg::OFS_STATUS: begin
          wb_dat_o[wrs_pkg::ST_RESET_LOW_BIT]  <= ~reset_out_b;
          wb_dat_o[wrs_pkg::ST_FAST_FAULT_BIT] <= stat_fast;
          wb_dat_o[wrs_pkg::ST_SLOW_FAULT_BIT] <= stat_slow;
          wb_dat_o[wrs_pkg::ST_WD_ENABLED_BIT] <= wd_enabled;
          wb_dat_o[wrs_pkg::ST_EXTENDED_BIT]   <= pins[wrs_pkg::PIN_MODE_SEL];
        end
        wrs_pkg::OFS_COUNT: begin
          wb_dat_o <= wd_count;
        end
        wrs_pkg::OFS_CAUSE: begin
          wb_dat_o[wrs_pkg::CAUSE_UV_SUPPLY_BIT]  <= pins[wrs_pkg::PIN_UV_SUPPLY];
          wb_dat_o[wrs_pkg::CAUSE_UV_MONITOR_BIT] <= pins[wrs_pkg::PIN_UV_MONITOR];
          wb_dat_o[wrs_pkg::CAUSE_MANUAL_BIT]     <= ~pins[wrs_pkg::PIN_MANUAL_B];
        end
        default: begin
          wb_dat_o <= '0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/wrs_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes each bit is a slow level; no bit relation is kept across bits.
*/
`timescale 1ns/1ps
`default_nettype none
module wrs_sync #(
  parameter int         W    = 8,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= INIT;
      pin_sync <= INIT;
    end else begin
      stage1   <= pin_async;
      pin_sync <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### test/watchdog_reset_supervisor_tb_top.sv
/* Top bench: bus tasks, reset causes and watchdog cases for wrs_supervisor.
   Assumes wrs_cpu_model drives the kick pin; 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_supervisor_tb_top;
  localparam int RT = 8;
  localparam int BW = 16;
  localparam int SW = 128;
  logic        clk, rst_b, cyc, stb, we, ack, rout_b, kick;
  logic        uv_s, uv_m, mr_b, mode, sa, sb, capg;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  int          per, miscompares, num_checks, cyc_cnt, t, len;
  // Window, mode, grounded cap, strap a, strap b, kick period, mode flip, fault time
  int          sc [11][8] = '{'{0, 0, 0, 0, 0, 12, 0, 0}, '{0, 0, 0, 0, 0, 0, 0, 16},
    '{0, 0, 0, 0, 0, 0, 10, 28}, '{0, 1, 0, 0, 0, 0, 0, 2048}, '{0, 0, 1, 0, 0, 0, 0, 0},
    '{1, 0, 0, 0, 0, 8, 0, 10}, '{1, 0, 0, 0, 1, 12, 0, 0}, '{1, 0, 0, 0, 1, 3, 0, 5},
    '{1, 0, 0, 1, 1, 6, 0, 0}, '{1, 0, 0, 1, 1, 0, 0, 128}, '{1, 0, 0, 1, 0, 0, 0, 0}};
  wrs_supervisor #(.RESET_TIMEOUT_CYCLES(RT), .BASIC_WD_CYCLES(BW), .SLOW_WINDOW_CYCLES(SW))
    wrs_supervisor_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .undervoltage_supply(uv_s), .undervoltage_monitor(uv_m),
    .manual_reset_input_b(mr_b), .watchdog_mode_select(mode), .window_ratio_strap_a(sa),
    .window_ratio_strap_b(sb), .watchdog_kick_input(kick),
    .watchdog_timing_capacitor_gnd(capg), .reset_out_b(rout_b));
  wrs_cpu_model wrs_cpu_model_inst (.clk(clk), .reset_out_b(rout_b),
    .kick_period(per[15:0]), .kick(kick));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_hi(output int n);
    n = 0;
    while (rout_b !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // High time until a fault, then the length of its low pulse
  task automatic meas(input int tog, output int th, output int tl);
    wait_hi(tl);
    th = 0;
    tl = 0;
    while (rout_b === 1'b1 && th < 2300) begin
      @(posedge clk);
      th++;
      if (tog != 0 && (th == tog || th == tog + 1)) mode <= ~mode;
    end
    while (rout_b === 1'b0 && tl < 50) begin
      @(posedge clk);
      tl++;
    end
  endtask
  initial begin
    {rst_b, cyc, stb, we, uv_s, uv_m, mode, sa, sb, capg} = '0;
    mr_b = 1'b1;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    per = 12;
    {miscompares, num_checks, cyc_cnt} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wait_hi(t);
    chk("por_low", 32'h1, 32'(t >= RT));
    wb(1'b0, wrs_pkg::OFS_CTRL, 32'h0, rd);
    chk("ctrl_rst", 32'(wrs_pkg::CTRL_RESET), rd);
    wb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 3; i++) begin
      uv_s <= (i == 0);
      uv_m <= (i == 1);
      mr_b <= (i != 2);
      repeat (20) @(posedge clk);
      chk("held", 32'h0, 32'(rout_b));
      wb(1'b0, wrs_pkg::OFS_CAUSE, 32'h0, rd);
      chk("cause", 32'h1 << i, rd);
      wb(1'b0, wrs_pkg::OFS_COUNT, 32'h0, rd);
      chk("count_in_reset", 32'h0, rd);
      wb(1'b0, wrs_pkg::OFS_STATUS, 32'h0, rd);
      chk("status_in_reset", 32'(1 << wrs_pkg::ST_RESET_LOW_BIT | 1 << wrs_pkg::ST_WD_ENABLED_BIT), rd);
      {uv_s, uv_m, mr_b} <= 3'h1;
      wait_hi(t);
      chk("release", 32'h1, 32'(t >= RT && t <= RT + 5));
    end
    foreach (sc[i]) begin
      mode <= 1'(sc[i][1]);
      capg <= 1'(sc[i][2]);
      sa <= 1'(sc[i][3]);
      sb <= 1'(sc[i][4]);
      per <= sc[i][5];
      wb(1'b1, wrs_pkg::OFS_CTRL, 32'(sc[i][0]) | 32'h2, rd);
      repeat (4) @(posedge clk);
      wb(1'b1, wrs_pkg::OFS_CTRL, 32'(sc[i][0]), rd);
      meas(sc[i][6], t, len);
      if (sc[i][7] == 0) begin
        chk("no_pulse", 32'h0, 32'(len));
      end else begin
        chk("pulse", 32'(RT), 32'(len));
        chk("wd_time", 32'h1, 32'(t >= sc[i][7] - 3 && t <= sc[i][7] + 6));
      end
    end
    wb(1'b0, wrs_pkg::OFS_STATUS, 32'h0, rd);
    chk("sticky", 32'h3, 32'(rd[2:1]));
    wb(1'b1, wrs_pkg::OFS_STATUS, 32'h6, rd);
    wb(1'b0, wrs_pkg::OFS_STATUS, 32'h0, rd);
    chk("w1c", 32'h0, 32'(rd[2:1]));
    end_of_test();
  end
endmodule
`default_nettype wire

// ### test/wrs_cpu_model.sv
/* Processor model: pulls the kick pin low for one cycle every period.
   Assumes period 0 stands for a stalled processor that never kicks. */
`timescale 1ns/1ps
`default_nettype none
module wrs_cpu_model (
  // Clock and processor reset
  input  wire logic        clk,
  input  wire logic        reset_out_b,
  // Behaviour
  input  wire logic [15:0] kick_period,
  // Kick pin
  output logic             kick
);
  logic [15:0] cnt    = 16'h0;
  logic        kick_r = 1'b1;
  assign kick = kick_r;
  // Held in reset the processor runs no code, so it cannot kick
  always @(posedge clk) begin
    if (!reset_out_b) begin
      cnt    <= 16'h0;
      kick_r <= 1'b1;
    end else begin
      cnt    <= (cnt + 16'h1 >= kick_period) ? 16'h0 : cnt + 16'h1;
      kick_r <= !(kick_period != 16'h0 && cnt + 16'h1 >= kick_period);
    end
  end
endmodule
`default_nettype wire

// ### test/wrs_supervisor_asserts.sv
/* Concurrent checks on the supervisor's ports, bound into wrs_supervisor.
   Assumes pins change only right after clock edges. */
`timescale 1ns/1ps
`default_nettype none
module wrs_supervisor_asserts #(
  parameter int RESET_TIMEOUT_CYCLES = 8,
  parameter int BASIC_WD_CYCLES      = 16,
  parameter int SLOW_WINDOW_CYCLES   = 128
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // Pins
  input  wire logic        undervoltage_supply,
  input  wire logic        undervoltage_monitor,
  input  wire logic        manual_reset_input_b,
  input  wire logic        watchdog_mode_select,
  input  wire logic        window_ratio_strap_a,
  input  wire logic        window_ratio_strap_b,
  input  wire logic        watchdog_kick_input,
  input  wire logic        watchdog_timing_capacitor_gnd,
  input  wire logic        reset_out_b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [4:0] pin_q;
  logic       win, clr;
  int         quiet, low_n, fast;
  // Mode select clears only the single timer, straps only the windowed one
  assign clr = !reset_out_b || win != pin_q[1] || (win ? (window_ratio_strap_a &&
    !window_ratio_strap_b) || {window_ratio_strap_a, window_ratio_strap_b} != pin_q[3:2]
    || (pin_q[0] && !watchdog_kick_input) : watchdog_timing_capacitor_gnd
    || watchdog_mode_select != pin_q[4] || watchdog_kick_input != pin_q[0]);
  assign fast = SLOW_WINDOW_CYCLES >> (window_ratio_strap_a ? 6 : window_ratio_strap_b ? 4 : 3);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win   <= 1'b0;
      pin_q <= 5'h01;
      quiet <= 0;
      low_n <= 0;
    end else begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
          && wb_adr_i == wrs_pkg::OFS_CTRL) begin
        win <= wb_dat_i[wrs_pkg::CTRL_WINDOWED_BIT];
      end
      pin_q <= {watchdog_mode_select, window_ratio_strap_a, window_ratio_strap_b, win,
                watchdog_kick_input};
      quiet <= clr ? 0 : quiet + 1;
      low_n <= reset_out_b ? 0 : low_n + 1;
    end
  end
  property p_uv_supply;
    undervoltage_supply [*5] |-> !reset_out_b;
  endproperty
  a_uv_supply: assert property (p_uv_supply) else $error("reset high in undervoltage");
  property p_mon_manual;
    (undervoltage_monitor || !manual_reset_input_b) [*5] |-> !reset_out_b;
  endproperty
  a_mon_manual: assert property (p_mon_manual) else $error("reset high with cause");
  property p_hold_time;
    $rose(reset_out_b) |-> low_n >= RESET_TIMEOUT_CYCLES;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("reset pulse too short");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_single_limit;
    reset_out_b && !win |-> quiet <= (watchdog_mode_select ? BASIC_WD_CYCLES * 128
                                      : BASIC_WD_CYCLES) + 6;
  endproperty
  a_single_limit: assert property (p_single_limit) else $error("no timeout");
  property p_slow_limit;
    reset_out_b && win |-> quiet <= SLOW_WINDOW_CYCLES + 6;
  endproperty
  a_slow_limit: assert property (p_slow_limit) else $error("no slow fault");
  property p_fast_fault;
    $fell(watchdog_kick_input) && reset_out_b && win && quiet + 4 < fast |-> ##[1:6] !reset_out_b;
  endproperty
  a_fast_fault: assert property (p_fast_fault) else $error("no fast fault");
  c_fault_pulse: cover property ($rose(reset_out_b) && low_n == RESET_TIMEOUT_CYCLES);
  c_fast_kick: cover property ($fell(watchdog_kick_input) && reset_out_b && win && quiet < 4);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind wrs_supervisor wrs_supervisor_asserts #(.RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES),
  .BASIC_WD_CYCLES(BASIC_WD_CYCLES), .SLOW_WINDOW_CYCLES(SLOW_WINDOW_CYCLES))
  wrs_supervisor_asserts_inst (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .undervoltage_supply, .undervoltage_monitor,
  .manual_reset_input_b, .watchdog_mode_select, .window_ratio_strap_a, .window_ratio_strap_b,
  .watchdog_kick_input, .watchdog_timing_capacitor_gnd, .reset_out_b);
`default_nettype wire
